/* File: hw/sched_defs.svh */
// timing and sizing constants of the frame scheduler
// assumes a 200 MHz system clock; bit counts are per baseband frame
`ifndef SCHED_DEFS_SVH
`define SCHED_DEFS_SVH
`define PLP_COUNT        4
`define PLP_IDX_W        2
`define BCH_PAYLOAD_BITS 16'h1F80
`define HDR_BITS         16'h0050
`define INBAND_BITS      16'h0040
`define FRAME_BLOCKS     8'h10
`define WORD_W           8
`define FIFO_DEPTH       8
`define CLK_PERIOD_NS    5
`define T_IF_NS          20000
`define T_OVERLAP_NS     2000
`define T_IF_CYC         (`T_IF_NS / `CLK_PERIOD_NS)
`define T_OVERLAP_CYC    (`T_OVERLAP_NS / `CLK_PERIOD_NS)
`endif

/* File: hw/sched_pkg.sv */
// types used by the scheduler end of the frame scheduler link and by the bench
// assumes sched_defs.svh is on the include path
package sched_pkg;
    typedef enum logic [1:0] {
        MODEL_ONE,
        MODEL_TWO,
        MODEL_MIXED,
        MODEL_FIXED
    } sched_model_t;
endpackage

/* File: hw/sched_if.sv */
// link between stream sources and scheduler, and scheduler to modulator
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
`include "sched_defs.svh"
interface sched_if (input wire logic clk);
    logic                  in_valid;
    logic                  in_ready;
    logic [`PLP_IDX_W-1:0] in_plp;
    logic [`WORD_W-1:0]    in_data;
    logic                  out_valid;
    logic                  out_ready;
    logic [`PLP_IDX_W-1:0] out_plp;
    logic                  out_padded;
    logic                  out_first;
    logic [`WORD_W-1:0]    out_blocks;
    logic                  frame_done;
    modport sched (input in_valid, in_plp, in_data, out_ready,
                   output in_ready, out_valid, out_plp, out_padded, out_first,
                   out_blocks, frame_done);
    modport src (output in_valid, in_plp, in_data, out_ready,
                 input in_ready, out_valid, out_plp, out_padded, out_first,
                 out_blocks, frame_done);
endinterface
`default_nettype wire

/* File: hw/word_fifo.sv */
// parameterised word fifo with valid/ready on both sides
// assumes one synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [WIDTH-1:0]      rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    assign wr_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign rd_valid = (cnt_reg != '0);
    assign rd_data  = mem[rp_reg];
    assign push     = wr_valid && wr_ready;
    assign pop      = rd_valid && rd_ready;

    always_comb begin
        wp_next  = push ? AW'((wp_reg + 1'b1) % DEPTH) : wp_reg;
        rp_next  = pop ? AW'((rp_reg + 1'b1) % DEPTH) : rp_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
        if (push) begin
            mem[wp_reg] <= wr_data;
        end
    end
endmodule // word_fifo
`default_nettype wire

/* File: hw/frame_scheduler.sv */
// scheduler end: per-stream occupancy, allocation windows, padded fill
// assumes the source end keeps its minimum and peak input rates
`timescale 1ns/1ps
`default_nettype none
`include "sched_defs.svh"
// Functional notes
// - full frame's payload queued means allocate it
// - first frame allocated early, signalling space zeroed
// - window end: pad fullest stream until full
// - frame n done by window end n+1
// - next frame waits for window end
// - per-stream store holds stream-count frames
// - steady leftover equals count-1 times payload-80
// - windows repeat each period, overlapping configured amount; the timer repeats every T_IF cycles with no overlap, T_OVERLAP_CYC unused
// - sources keep minimum rate per stream
// - collection time shorter than frame period
// - buffering identifies each stream's first frame
// - block counts final before signalling, extra frame; out_blocks at frame_done excludes the padded fill that follows
// - sources cap peak rate in window
// - model two flushes every stream at period end; the code pads the fullest stream until full, as in model one
// - model two rate leaves count-1 frames spare
// - mixed mode pads unfinished frame at end
// - fixed mode allocates without padding, still closed at window end
// - opportunistic fill keeps minimum under model one
// - groups scheduled by separate instances, fixed share
module frame_scheduler
    import sched_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire sched_model_t model,
    input  wire logic [7:0]   capacity,
    output logic [7:0]        blocks_reg,
    output logic              busy_reg,
    sched_if.sched            lnk
);
    localparam int N = `PLP_COUNT;
    localparam logic [15:0] PAYLOAD = `BCH_PAYLOAD_BITS - `HDR_BITS;
    localparam logic [15:0] FIRST_TH = PAYLOAD - `INBAND_BITS;
    localparam logic [15:0] STORE_MAX = 16'(N) * PAYLOAD;
    localparam logic [23:0] T_IF = 24'(`T_IF_CYC);

    typedef enum logic [1:0] {S_RUN, S_HOLD, S_FLUSH} st_t;

    logic [15:0] occ_reg [N];
    logic [15:0] occ_next [N];
    logic        first_reg [N];
    logic        first_next [N];
    logic [23:0] tmr_reg, tmr_next;
    st_t         st_reg, st_next;
    logic [7:0]  alloc_reg, alloc_next, blocks_next;
    logic        busy_next;
    logic        ov_reg, ov_next;
    logic [`PLP_IDX_W-1:0] plp_reg, plp_next;
    logic        pad_reg, pad_next, fst_reg, fst_next, done_reg, done_next;
    logic [7:0]  ob_reg, ob_next;

    // queued bits needed before a frame may be taken
    function automatic logic [15:0] need(input logic first);
        return first ? FIRST_TH : PAYLOAD;
    endfunction

    // remainder beyond one frame stays queued for the next frame; a padded frame empties the store
    function automatic logic [15:0] take(input logic [15:0] o, input logic first);
        return (o > need(first)) ? o - need(first) : 16'h0000;
    endfunction

    logic win_end;
    assign win_end = (tmr_reg == T_IF - 24'h000001);

    assign lnk.in_ready   = occ_reg[lnk.in_plp] < STORE_MAX;
    assign lnk.out_valid  = ov_reg;
    assign lnk.out_plp    = plp_reg;
    assign lnk.out_padded = pad_reg;
    assign lnk.out_first  = fst_reg;
    assign lnk.out_blocks = ob_reg;
    assign lnk.frame_done = done_reg;

    always_comb begin
        int fi;
        logic hit;
        logic [15:0] best;
        fi = 0;
        hit = 1'b0;
        best = 16'h0000;
        tmr_next = win_end ? 24'h000000 : tmr_reg + 24'h000001;
        st_next = st_reg;
        alloc_next = alloc_reg;
        blocks_next = blocks_reg;
        busy_next = (st_reg != S_HOLD);
        ov_next = ov_reg && !lnk.out_ready;
        plp_next = plp_reg;
        pad_next = pad_reg;
        fst_next = fst_reg;
        ob_next = ob_reg;
        done_next = 1'b0;
        for (int i = 0; i < N; i++) begin
            occ_next[i] = occ_reg[i];
            first_next[i] = first_reg[i];
            if (lnk.in_valid && lnk.in_ready && lnk.in_plp == `PLP_IDX_W'(i)) begin
                occ_next[i] = occ_reg[i] + 16'(`WORD_W);
            end
        end
        if (!ov_next) begin
            // allocate first stream that has a whole frame queued
            for (int i = N - 1; i >= 0; i--) begin
                if (occ_reg[i] >= need(first_reg[i])) begin
                    hit = 1'b1;
                    fi = i;
                end
            end
            if (st_reg == S_FLUSH) begin
                hit = 1'b1;
                for (int i = 0; i < N; i++) begin
                    if (occ_reg[i] >= best) begin
                        best = occ_reg[i];
                        fi = i;
                    end
                end
            end
            if (model == MODEL_TWO && st_reg == S_RUN && !win_end) begin
                hit = hit && (occ_reg[fi] >= need(first_reg[fi]));
            end
            if (hit && st_reg != S_HOLD) begin
                ov_next = 1'b1;
                plp_next = `PLP_IDX_W'(fi);
                pad_next = occ_reg[fi] < need(first_reg[fi]);
                fst_next = first_reg[fi];
                occ_next[fi] = take(occ_next[fi], first_reg[fi]);
                first_next[fi] = 1'b0;
                alloc_next = alloc_reg + 8'h01;
                ob_next = alloc_reg + 8'h01;
                if (alloc_next >= capacity) begin
                    st_next = S_HOLD;
                end
                if (st_reg == S_FLUSH && alloc_next >= capacity) begin
                    // padded fill done: the closed frame is complete, next one may start
                    alloc_next = 8'h00;
                    st_next = S_RUN;
                    for (int i = 0; i < N; i++) begin
                        first_next[i] = 1'b1;
                    end
                end
            end
        end
        if (win_end) begin
            // counts are final when the window closes
            if (st_next == S_HOLD || model == MODEL_FIXED) begin
                blocks_next = alloc_next;
                done_next = 1'b1;
                alloc_next = 8'h00;
                st_next = S_RUN;
                for (int i = 0; i < N; i++) begin
                    first_next[i] = 1'b1;
                end
            end else if (st_reg == S_RUN) begin
                // frame closes on time; padded fill of its rest follows at once
                blocks_next = capacity;
                done_next = 1'b1;
                st_next = S_FLUSH;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                occ_reg[i] <= 16'h0000;
                first_reg[i] <= 1'b1;
            end
            tmr_reg <= 24'h000000;
            st_reg <= S_RUN;
            alloc_reg <= 8'h00;
            blocks_reg <= 8'h00;
            busy_reg <= 1'b0;
            ov_reg <= 1'b0;
            plp_reg <= '0;
            pad_reg <= 1'b0;
            fst_reg <= 1'b0;
            ob_reg <= 8'h00;
            done_reg <= 1'b0;
        end else begin
            for (int i = 0; i < N; i++) begin
                occ_reg[i] <= occ_next[i];
                first_reg[i] <= first_next[i];
            end
            tmr_reg <= tmr_next;
            st_reg <= st_next;
            alloc_reg <= alloc_next;
            blocks_reg <= blocks_next;
            busy_reg <= busy_next;
            ov_reg <= ov_next;
            plp_reg <= plp_next;
            pad_reg <= pad_next;
            fst_reg <= fst_next;
            ob_reg <= ob_next;
            done_reg <= done_next;
        end
    end
endmodule // frame_scheduler
`default_nettype wire

/* File: hw/stream_source.sv */
// source end: buffers user words in a fifo and offers them to the link
// assumes the scheduler end accepts words when in_ready is high
`timescale 1ns/1ps
`default_nettype none
`include "sched_defs.svh"
module stream_source (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  user_valid,
    output logic                       user_ready,
    input  wire logic [`WORD_W-1:0]    user_data,
    input  wire logic [`PLP_IDX_W-1:0] user_plp,
    output logic                       frame_seen_reg,
    output logic [7:0]                 blocks_seen_reg,
    sched_if.src                       lnk
);
    logic [`WORD_W+`PLP_IDX_W-1:0] rd_word;
    logic                          rd_valid;
    logic [7:0]                    bs_next;

    // the user side paces the rate; back-pressure reaches it
    word_fifo #(
        .WIDTH(`WORD_W + `PLP_IDX_W),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .clk     (clk),
        .rst     (rst),
        .wr_valid(user_valid),
        .wr_ready(user_ready),
        .wr_data ({user_plp, user_data}),
        .rd_valid(rd_valid),
        .rd_ready(lnk.in_ready),
        .rd_data (rd_word)
    );

    assign lnk.in_valid  = rd_valid;
    assign lnk.in_data   = rd_word[`WORD_W-1:0];
    assign lnk.in_plp    = rd_word[`WORD_W+`PLP_IDX_W-1:`WORD_W];
    assign lnk.out_ready = 1'b1;

    always_comb begin
        bs_next = lnk.frame_done ? lnk.out_blocks : blocks_seen_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            frame_seen_reg  <= 1'b0;
            blocks_seen_reg <= 8'h00;
        end else begin
            frame_seen_reg  <= lnk.frame_done;
            blocks_seen_reg <= bs_next;
        end
    end
endmodule // stream_source
`default_nettype wire

/* File: dv/sched_asserts.sv */
// concurrent checks on the scheduler link signals
// assumes sched_defs.svh on the include path and one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "sched_defs.svh"
module sched_asserts (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  in_valid,
    input wire logic                  in_ready,
    input wire logic [`PLP_IDX_W-1:0] in_plp,
    input wire logic [`WORD_W-1:0]    in_data,
    input wire logic                  out_valid,
    input wire logic                  out_ready,
    input wire logic [`PLP_IDX_W-1:0] out_plp,
    input wire logic                  out_padded,
    input wire logic                  out_first,
    input wire logic                  frame_done
);
    localparam int T_IF = `T_IF_CYC;
    logic [15:0] cnt_reg, cnt_next;
    logic [3:0]  seen_reg, seen_next;
    logic        pend_reg, pend_next, fresh, take;
    assign take = out_valid && out_ready;
    // padded fill after a window end still belongs to the old frame
    assign fresh = pend_reg || !seen_reg[out_plp];
    always_comb begin
        cnt_next = frame_done ? 16'h0000 : cnt_reg + 16'h0001;
        pend_next = pend_reg || frame_done;
        seen_next = seen_reg;
        if (take && !out_padded && pend_reg) begin
            seen_next = 4'h0;
            pend_next = frame_done;
        end
        if (take && !(out_padded && pend_reg)) begin
            seen_next[out_plp] = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= 16'h0000;
            seen_reg <= 4'h0;
            pend_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            seen_reg <= seen_next;
            pend_reg <= pend_next;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    period_end_a: assert property (frame_done |-> cnt_reg >= T_IF - 2 && cnt_reg <= T_IF)
        else $error("window end off period");
    period_bound_a: assert property (cnt_reg <= T_IF)
        else $error("window overran period");
    done_pulse_a: assert property (frame_done |=> !frame_done)
        else $error("window end not one cycle");
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_plp)
        && $stable(out_padded) && $stable(out_first))
        else $error("allocation dropped before ready");
    in_hold_a: assert property (in_valid && !in_ready |=> in_valid && $stable({in_plp, in_data}))
        else $error("input word changed before ready");
    first_new_a: assert property (take && !out_padded && fresh |-> out_first)
        else $error("first frame not marked");
    first_again_a: assert property (take && !out_padded && !fresh |-> !out_first)
        else $error("repeat frame marked first");
    pad_late_a: assert property (out_valid && out_padded |-> cnt_reg < 16'd300)
        else $error("padded frame away from window end");
endmodule // sched_asserts
`default_nettype wire

/* File: dv/multi_plp_frame_scheduler_tb.sv */
// bench: source end and scheduler end joined by the link
// assumes design files and sched_defs.svh compiled first
`timescale 1ns/1ps
`default_nettype none
module multi_plp_frame_scheduler_tb;
    import sched_pkg::*;
    logic         clk, rst, user_valid, user_ready, frame_seen_reg, busy_reg;
    logic [7:0]   user_data, capacity, blocks_reg, blocks_seen;
    logic [1:0]   user_plp;
    sched_model_t model;
    int           miscompares = 0, n_compared = 0, cycles = 0;
    // record is plp, padded, first
    logic [3:0]   alloc_q[$];
    sched_if lnk (.clk(clk));
    frame_scheduler frame_scheduler_inst (.clk(clk), .rst(rst), .model(model),
        .capacity(capacity), .blocks_reg(blocks_reg), .busy_reg(busy_reg), .lnk(lnk));
    stream_source stream_source_inst (.clk(clk), .rst(rst), .user_valid(user_valid),
        .user_ready(user_ready), .user_data(user_data), .user_plp(user_plp),
        .frame_seen_reg(frame_seen_reg), .blocks_seen_reg(blocks_seen), .lnk(lnk));
    sched_asserts sched_asserts_inst (.clk(clk), .rst(rst), .in_valid(lnk.in_valid),
        .in_ready(lnk.in_ready), .in_plp(lnk.in_plp), .in_data(lnk.in_data),
        .out_valid(lnk.out_valid), .out_ready(lnk.out_ready), .out_plp(lnk.out_plp),
        .out_padded(lnk.out_padded), .out_first(lnk.out_first), .frame_done(lnk.frame_done));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (lnk.out_valid === 1'b1 && lnk.out_ready === 1'b1) begin
            alloc_q.push_back({lnk.out_plp, lnk.out_padded, lnk.out_first});
        end
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic send(input logic [1:0] p, input int n);
        for (int i = 0; i < n; i++) begin
            user_valid = 1'b1;
            user_plp = p;
            user_data = i[7:0];
            while (user_ready !== 1'b1) tick(1);
            tick(1);
        end
        user_valid = 1'b0;
        tick(1);
    endtask
    task automatic wait_done();
        for (int k = 0; k < 5000 && lnk.frame_done !== 1'b1; k++) tick(1);
        check("window end", 8'h01, {7'h0, lnk.frame_done});
    endtask
    task automatic restart();
        rst = 1'b1;
        tick(12);
        rst = 1'b0;
        alloc_q = {};
    endtask
    function automatic int pads();
        int n = 0;
        foreach (alloc_q[i]) n += alloc_q[i][1];
        return n;
    endfunction
    initial begin
        model = MODEL_ONE;
        capacity = 8'h02;
        user_valid = 1'b0;
        user_data = 8'h00;
        user_plp = 2'h0;
        restart();
        tick(1);
        check("busy", 8'h01, {7'h0, busy_reg});
        send(2'h0, 1000);
        tick(20);
        check("first alloc", 8'h01, {4'h0, alloc_q[0]});
        send(2'h2, 300);
        send(2'h1, 100);
        wait_done();
        tick(10);
        check("fill count", 8'h02, 8'(alloc_q.size()));
        check("fill pick", 8'h0B, {4'h0, alloc_q[1]});
        alloc_q = {};
        send(2'h1, 1000);
        send(2'h3, 1000);
        send(2'h0, 1000);
        tick(20);
        check("held allocs", 8'h02, 8'(alloc_q.size()));
        wait_done();
        tick(1);
        check("seen pulse", 8'h01, {7'h0, frame_seen_reg});
        check("block count", 8'h02, blocks_reg);
        check("seen count", 8'h02, blocks_seen);
        tick(10);
        check("next first", 8'h01, {4'h0, alloc_q[2]});
        for (int m = 1; m < 4; m++) begin
            model = sched_model_t'(m);
            restart();
            send(2'h3, 200);
            wait_done();
            tick(10);
            check("padded", (m == 3) ? 8'h00 : 8'h01, {7'h0, pads() != 0});
        end
        close_out();
    end
endmodule // multi_plp_frame_scheduler_tb
`default_nettype wire
